// *** design/hvi_pkg.sv ***
// package: register map, command codes, field layout and timing of the hv interface
package hvi_pkg;
	localparam logic [31:0] HVI_CMD_ADDR       = 32'hffff0804;
	localparam logic [31:0] HVI_DATA_ADDR      = 32'hffff080c;
	localparam int          HVI_BUSY_BIT       = 0;
	localparam int          HVI_RX_OK_BIT      = 1;
	localparam int          HVI_TX_OK_BIT      = 2;
	localparam int          HVI_TAG_LSB        = 8;
	localparam int          HVI_CODE_W         = 4;
	localparam int          HVI_BYTE_W         = 8;
	localparam int          HVI_DATA_W         = 12;
	localparam logic [7:0]  HVI_RD_CFG0        = 8'h00;
	localparam logic [7:0]  HVI_RD_CFG1        = 8'h01;
	localparam logic [7:0]  HVI_RD_STAT        = 8'h02;
	localparam logic [7:0]  HVI_RD_MON         = 8'h03;
	localparam logic [7:0]  HVI_WR_CFG0        = 8'h08;
	localparam logic [7:0]  HVI_WR_CFG1        = 8'h09;
	localparam logic [7:0]  HVI_CFG0_RST       = 8'h00;
	localparam logic [7:0]  HVI_BYTE_RST       = 8'h00;
	localparam logic [3:0]  HVI_TAG_RST        = 4'h0;
	localparam logic        HVI_OK_RST         = 1'b0;
	localparam logic        HVI_BUSY_RST       = 1'b0;
	localparam int          HVI_MCLK_MHZ       = 250;
	localparam int          HVI_LINK_KHZ       = 2560;
	localparam int          HVI_LATENCY_MAX_NS = 10000;
	// longest times round down to whole cycles
	localparam int          HVI_BUSY_MAX_CYC   = HVI_LATENCY_MAX_NS * HVI_MCLK_MHZ / 1000;
	localparam int          HVI_LINK_MAX_BITS  = HVI_LATENCY_MAX_NS / 1000 * HVI_LINK_KHZ / 1000;
	localparam logic [3:0]  HVI_RD_TX_BITS     = 4'h5;
	localparam logic [3:0]  HVI_WR_TX_BITS     = 4'hd;
	localparam logic [3:0]  HVI_RD_RX_BITS     = 4'h9;
	localparam logic [3:0]  HVI_WR_RX_BITS     = 4'h1;

	typedef enum logic [1:0] {
		HVI_L_IDLE = 2'b00,
		HVI_L_SEND = 2'b01,
		HVI_L_RECV = 2'b10,
		HVI_L_DONE = 2'b11
	} hvi_link_state_t;
endpackage

// *** design/hvi_link.sv ***
// serial link engine on the link clock: frames one command and collects the reply
module hvi_link (
	input  wire logic       lclk,
	input  wire logic       rst_b,
	input  wire logic       req_tgl,
	input  wire logic [3:0] req_code,
	input  wire logic [7:0] req_byte,
	output logic            done_tgl,
	output logic            res_ok,
	output logic [7:0]      res_byte,
	input  wire logic       sdata_i,
	output logic            sdata_o,
	output logic            sdata_oe
);
	typedef struct packed {
		logic                     s1;
		logic                     s2;
		logic                     s3;
		logic                     seen;
		hvi_pkg::hvi_link_state_t st;
		logic                     rd;
		logic [11:0]              sh;
		logic [3:0]               cnt;
		logic [8:0]               rx;
		logic                     ok;
		logic [7:0]               rbyte;
		logic                     done;
		logic                     so;
		logic                     soe;
		logic [4:0]               fcnt;
	} hvi_link_reg_t;

	localparam hvi_link_reg_t LINK_RST = '0;
	localparam int            FRAME_MAX = hvi_pkg::HVI_LINK_MAX_BITS;

	hvi_link_reg_t q;
	hvi_link_reg_t d;

	always_comb begin
		d = q;
		d.s1 = req_tgl;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.fcnt = q.fcnt + 5'h01;
		case (q.st)
			hvi_pkg::HVI_L_IDLE: begin
				d.fcnt = 5'h00;
				// request toggle counts once stages two and three agree
				if ((q.s2 == q.s3) && (q.s3 != q.seen)) begin
					d.seen = q.s3;
					d.rd   = ~req_code[3];
					d.sh   = {req_code, req_byte};
					d.cnt  = req_code[3] ? hvi_pkg::HVI_WR_TX_BITS - 4'h1 :
						hvi_pkg::HVI_RD_TX_BITS - 4'h1;
					d.rx   = 9'h000;
					d.so   = 1'b1;
					d.soe  = 1'b1;
					d.st   = hvi_pkg::HVI_L_SEND;
				end
			end
			hvi_pkg::HVI_L_SEND: begin
				if (q.cnt == 4'h0) begin
					d.so  = 1'b0;
					d.soe = 1'b0;
					d.cnt = q.rd ? hvi_pkg::HVI_RD_RX_BITS - 4'h1 :
						hvi_pkg::HVI_WR_RX_BITS - 4'h1;
					d.st  = hvi_pkg::HVI_L_RECV;
				end else begin
					d.so  = q.sh[11];
					d.sh  = {q.sh[10:0], 1'b0};
					d.cnt = q.cnt - 4'h1;
				end
			end
			hvi_pkg::HVI_L_RECV: begin
				d.rx = {q.rx[7:0], sdata_i};
				if (q.cnt == 4'h0) begin
					d.st = hvi_pkg::HVI_L_DONE;
				end else begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			hvi_pkg::HVI_L_DONE: begin
				// first reply bit is the acknowledge, a read adds the byte
				d.ok = q.rd ? q.rx[8] : q.rx[0];
				if (q.rd) begin
					d.rbyte = q.rx[7:0];
				end
				d.done = ~q.done;
				d.st   = hvi_pkg::HVI_L_IDLE;
			end
			default: begin
				d.st = hvi_pkg::HVI_L_IDLE;
			end
		endcase
	end

	always_ff @(posedge lclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= LINK_RST;
		end else begin
			q <= d;
		end
	end

	assign done_tgl = q.done;
	assign res_ok   = q.ok;
	assign res_byte = q.rbyte;
	assign sdata_o  = q.so;
	assign sdata_oe = q.soe;

	frame_bound_a: assert property (@(posedge lclk) disable iff (!rst_b)
		q.fcnt <= 5'(FRAME_MAX))
		else $error("link frame longer than latency budget");
	idle_release_a: assert property (@(posedge lclk) disable iff (!rst_b)
		(q.st == hvi_pkg::HVI_L_RECV) |-> !sdata_oe)
		else $error("data line driven while reply expected");
endmodule

// *** design/hvi_access.sv ***
// hv indirect access: command and data registers, crossing to the serial link engine
// Functional notes
// - command register bit 2 reads last write command outcome, 1 means success
// - command register bit 1 reads last read command outcome, 1 means success
// - command register bit 0 is read-only busy flag of the interface
// - status bits are valid once busy drops, invalid while it is high
// - data register is twelve bits wide, holding the transferred byte
// - data bits 11 to 8 read-only, show code of the byte
// - codes 00 to 03 fetch config0, config1, status, monitor into data
// - code 08 writes data byte to config0, code 09 to config1
// - data bits 7 to 0 carry the byte written or read back
// - config0 is an eight-bit read/write control register
// - config0 resets to zero and is reached only through command and data
// - each of the six valid command bytes is decoded as read or write to one register
// - two-wire serial link carries commands; latency stays within 10 us
module hvi_access (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic [31:0] mmr_addr,
	input  wire logic        mmr_wr,
	input  wire logic        mmr_rd,
	input  wire logic [31:0] mmr_wdata,
	output logic [31:0]      mmr_rdata,
	input  wire logic        lclk,
	input  wire logic        hv_sdata_i,
	output logic             hv_sdata_o,
	output logic             hv_sdata_oe,
	output logic [7:0]       hv_cfg_zero
);
	typedef struct packed {
		logic        busy;
		logic        tx_ok;
		logic        rx_ok;
		logic [3:0]  hold_code;
		logic [7:0]  hold_byte;
		logic        req_tgl;
		logic        a1;
		logic        a2;
		logic        a3;
		logic        aseen;
		logic [3:0]  dat_tag;
		logic [7:0]  dat_byte;
		logic [7:0]  cfg0;
		logic [31:0] rdata;
		logic [11:0] busy_cnt;
	} hvi_mcu_state_t;

	localparam hvi_mcu_state_t MCU_RST = '{
		busy:      hvi_pkg::HVI_BUSY_RST,
		tx_ok:     hvi_pkg::HVI_OK_RST,
		rx_ok:     hvi_pkg::HVI_OK_RST,
		hold_code: hvi_pkg::HVI_TAG_RST,
		hold_byte: hvi_pkg::HVI_BYTE_RST,
		req_tgl:   1'b0,
		a1:        1'b0,
		a2:        1'b0,
		a3:        1'b0,
		aseen:     1'b0,
		dat_tag:   hvi_pkg::HVI_TAG_RST,
		dat_byte:  hvi_pkg::HVI_BYTE_RST,
		cfg0:      hvi_pkg::HVI_CFG0_RST,
		rdata:     32'h00000000,
		busy_cnt:  12'h000
	};
	localparam int BUSY_MAX = hvi_pkg::HVI_BUSY_MAX_CYC;

	hvi_mcu_state_t q;
	hvi_mcu_state_t d;

	logic       link_done_tgl;
	logic       link_ok;
	logic [7:0] link_byte;
	logic       sel_cmd;
	logic       sel_data;
	logic       cmd_wr;
	logic       data_wr;
	logic       code_ok;
	logic       accept;
	logic       done_evt;
	logic [3:0] wr_code;
	logic [7:0] wr_byte;

	// only the six documented codes start a transfer
	function automatic logic cmd_is_valid(input logic [7:0] c);
		cmd_is_valid = (c == hvi_pkg::HVI_RD_CFG0) || (c == hvi_pkg::HVI_RD_CFG1) ||
			(c == hvi_pkg::HVI_RD_STAT) || (c == hvi_pkg::HVI_RD_MON) ||
			(c == hvi_pkg::HVI_WR_CFG0) || (c == hvi_pkg::HVI_WR_CFG1);
	endfunction

	assign sel_cmd  = (mmr_addr == hvi_pkg::HVI_CMD_ADDR);
	assign sel_data = (mmr_addr == hvi_pkg::HVI_DATA_ADDR);
	assign cmd_wr   = mmr_wr && sel_cmd;
	assign data_wr  = mmr_wr && sel_data;
	assign code_ok  = cmd_is_valid(mmr_wdata[7:0]);
	assign wr_code  = mmr_wdata[3:0];
	assign wr_byte  = mmr_wdata[7:0];
	// a command while busy is dropped, the pending one stays intact
	assign accept   = cmd_wr && code_ok && !q.busy;
	// acknowledge toggle counts once stages two and three agree
	assign done_evt = q.busy && (q.a2 == q.a3) && (q.a3 != q.aseen);

	always_comb begin
		d = q;
		if (ce) begin
			d.a1 = link_done_tgl;
			d.a2 = q.a1;
			d.a3 = q.a2;
			d.busy_cnt = q.busy ? q.busy_cnt + 12'h001 : 12'h000;

			// software writes only the byte, the tag stays hardware owned
			if (data_wr) begin
				d.dat_byte = wr_byte;
			end

			if (accept) begin
				d.busy      = 1'b1;
				d.hold_code = wr_code;
				d.hold_byte = q.dat_byte;
				d.req_tgl   = ~q.req_tgl;
			end

			// a successful read completion overrides a software byte write in the same cycle
			if (done_evt) begin
				d.aseen   = q.a3;
				d.busy    = 1'b0;
				d.dat_tag = q.hold_code;
				if (q.hold_code[3]) begin
					d.tx_ok = link_ok;
					if (link_ok && (q.hold_code == hvi_pkg::HVI_WR_CFG0[3:0])) begin
						d.cfg0 = q.hold_byte;
					end
				end else begin
					d.rx_ok = link_ok;
					if (link_ok) begin
						d.dat_byte = link_byte;
					end
				end
			end

			if (mmr_rd) begin
				if (sel_cmd) begin
					d.rdata = 32'h00000000;
					d.rdata[hvi_pkg::HVI_TX_OK_BIT] = q.tx_ok;
					d.rdata[hvi_pkg::HVI_RX_OK_BIT] = q.rx_ok;
					d.rdata[hvi_pkg::HVI_BUSY_BIT]  = q.busy;
				end else if (sel_data) begin
					d.rdata = {20'h00000, q.dat_tag, q.dat_byte};
				end else begin
					d.rdata = 32'h00000000;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q <= MCU_RST;
		end else begin
			q <= d;
		end
	end

	hvi_link u_link (
		.lclk     (lclk),
		.rst_b    (rst_b),
		.req_tgl  (q.req_tgl),
		.req_code (q.hold_code),
		.req_byte (q.hold_byte),
		.done_tgl (link_done_tgl),
		.res_ok   (link_ok),
		.res_byte (link_byte),
		.sdata_i  (hv_sdata_i),
		.sdata_o  (hv_sdata_o),
		.sdata_oe (hv_sdata_oe)
	);

	assign mmr_rdata   = q.rdata;
	assign hv_cfg_zero = q.cfg0;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	cmd_accept_a: assert property (
		(ce && accept) |=> (q.busy && (q.hold_code == $past(wr_code))))
		else $error("valid command not taken");

	invalid_drop_a: assert property (
		(ce && cmd_wr && !code_ok && !q.busy && !done_evt) |=> !q.busy)
		else $error("invalid command started a transfer");

	busy_refuse_a: assert property (
		(ce && cmd_wr && q.busy) |=> ($stable(q.hold_code) && $stable(q.hold_byte)))
		else $error("command accepted while busy");

	busy_drop_a: assert property (
		(ce && done_evt) |=> !q.busy)
		else $error("busy not cleared at completion");

	status_valid_a: assert property (
		$fell(q.busy) |-> (q.hold_code[3] ? (q.tx_ok == $past(link_ok)) :
			(q.rx_ok == $past(link_ok))))
		else $error("status invalid after busy fell");

	status_read_a: assert property (
		(ce && mmr_rd && sel_cmd) |=> ((mmr_rdata[2:0] ==
			{$past(q.tx_ok), $past(q.rx_ok), $past(q.busy)})))
		else $error("command register read wrong status");

	reserved_zero_a: assert property (
		(ce && mmr_rd && sel_cmd) |=> (mmr_rdata[31:3] == 29'h00000000))
		else $error("reserved command bits not zero");

	data_width_a: assert property (
		(ce && mmr_rd && sel_data) |=> ((mmr_rdata[31:12] == 20'h00000) &&
			(mmr_rdata[11:8] == $past(q.dat_tag))))
		else $error("data register read wrong");

	tag_follow_a: assert property (
		(ce && done_evt) |=> (q.dat_tag == $past(q.hold_code)))
		else $error("data tag not set to command code");

	tag_readonly_a: assert property (
		(ce && data_wr && !done_evt) |=> ($stable(q.dat_tag) &&
			(q.dat_byte == $past(wr_byte))))
		else $error("software write changed tag or lost byte");

	read_fetch_a: assert property (
		(ce && done_evt && !q.hold_code[3] && link_ok) |=>
			(q.rx_ok && (q.dat_byte == $past(link_byte))))
		else $error("read back byte not stored");

	write_status_a: assert property (
		(ce && done_evt && q.hold_code[3]) |=> ((q.tx_ok == $past(link_ok)) &&
			$stable(q.rx_ok)))
		else $error("write status wrong");

	cfg0_write_a: assert property (
		(ce && done_evt && link_ok && (q.hold_code == hvi_pkg::HVI_WR_CFG0[3:0])) |=>
			(hv_cfg_zero == $past(q.hold_byte)))
		else $error("config0 copy not updated");

	cfg0_hold_a: assert property (
		!(ce && done_evt && link_ok && (q.hold_code == hvi_pkg::HVI_WR_CFG0[3:0])) |=>
			$stable(hv_cfg_zero))
		else $error("config0 changed without its write command");

	busy_bound_a: assert property (
		q.busy_cnt <= 12'(BUSY_MAX))
		else $error("command latency over budget");
endmodule

// *** bench/hvi_far_model.sv ***
// far-end model of the hv die: four indirect registers behind the serial link
module hvi_far_model #(
	parameter logic [7:0] STA_V = 8'h5a,
	parameter logic [7:0] MON_V = 8'hc3
) (
	input  wire logic lclk,
	input  wire logic rst_b,
	input  wire logic line,
	input  wire logic dev_oe,
	input  wire logic ack_en,
	output logic      far_o,
	output logic      far_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] sh;
	logic [12:0] sh_n;
	logic [3:0]  n;
	logic [3:0]  n_n;
	logic [3:0]  rx;
	logic [7:0]  rb;
	logic [7:0]  regs [4];
	assign sh_n = {sh[11:0], line};
	assign n_n  = n + 4'h1;
	always @(posedge lclk or negedge rst_b) begin
		if (!rst_b) begin
			regs   <= '{8'h00, 8'h00, STA_V, MON_V};
			sh     <= 13'h0000;
			n      <= 4'h0;
			rx     <= 4'h0;
			rb     <= 8'h00;
			far_oe <= 1'b0;
			far_o  <= 1'b0;
		end else begin
			far_oe <= 1'b0;
			if (rx != 4'h0) begin
				far_oe <= 1'b1;
				far_o  <= rb[7];
				rb     <= {rb[6:0], 1'b0};
				rx     <= rx - 4'h1;
			end
			if (dev_oe) begin
				sh <= sh_n;
				n  <= n_n;
				// a read frame ends after start and code, a write frame after its byte
				if ((n_n == 4'h5 && !sh_n[3]) || n_n == 4'hd) begin
					far_oe <= ack_en;
					far_o  <= 1'b1;
					if (n_n == 4'h5) begin
						rb <= regs[sh_n[1:0]];
						rx <= ack_en ? 4'h8 : 4'h0;
					end else if (ack_en) begin
						regs[{1'b0, sh_n[8]}] <= sh_n[7:0];
					end
				end
			end else begin
				n <= 4'h0;
			end
		end
	end
endmodule

// *** bench/test_hv_indirect_register_access.sv ***
// self-checking bench of the hv indirect access block with a far-end model
module test_hv_indirect_register_access;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] STA_V = 8'h5a;
	localparam logic [7:0] MON_V = 8'hc3;
	logic        mclk, rst_b, ce, mmr_wr, mmr_rd, lclk, ack_en;
	logic [31:0] mmr_addr, mmr_wdata, mmr_rdata, seed, r;
	logic        hv_sdata_o, hv_sdata_oe, far_o, far_oe, sdl, txok, rxok;
	logic [7:0]  hv_cfg_zero, db, cfg0;
	logic [3:0]  tag;
	logic [7:0]  mreg [4];
	logic [7:0]  bad [5];
	int          fails, check_count, i;
	// the line is pulled low when nobody drives it
	assign sdl = hv_sdata_oe ? hv_sdata_o : (far_oe ? far_o : 1'b0);
	hvi_access dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr),
		.mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata), .lclk(lclk),
		.hv_sdata_i(sdl), .hv_sdata_o(hv_sdata_o), .hv_sdata_oe(hv_sdata_oe),
		.hv_cfg_zero(hv_cfg_zero));
	hvi_far_model #(.STA_V(STA_V), .MON_V(MON_V)) far (.lclk(lclk), .rst_b(rst_b), .line(sdl),
		.dev_oe(hv_sdata_oe), .ack_en(ack_en), .far_o(far_o), .far_oe(far_oe));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		lclk = 1'b0;
		#5;
		forever #16 lclk = ~lclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		#1 mmr_wr = 1'b1;
		mmr_addr = a;
		mmr_wdata = d;
		@(posedge mclk);
		#1 mmr_wr = 1'b0;
	endtask
	task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge mclk);
		#1 mmr_rd = 1'b1;
		mmr_addr = a;
		@(posedge mclk);
		#1 mmr_rd = 1'b0;
		@(posedge mclk);
		#1 d = mmr_rdata;
	endtask
	task automatic chk_regs();
		bus_rd(hvi_pkg::HVI_CMD_ADDR, r);
		check(r, {29'h0, txok, rxok, 1'b0});
		bus_rd(hvi_pkg::HVI_DATA_ADDR, r);
		check(r, {20'h0, tag, db});
		check({24'h0, hv_cfg_zero}, {24'h0, cfg0});
	endtask
	// stress adds a refused command while busy and a clock-enable pause
	task automatic run_cmd(input logic [7:0] c, input logic ack, input logic stress);
		int  k;
		time t0;
		ack_en = ack;
		bus_wr(hvi_pkg::HVI_CMD_ADDR, {24'h0, c});
		t0 = $time;
		if (stress) bus_wr(hvi_pkg::HVI_CMD_ADDR, {24'h0, c ^ 8'h01});
		bus_rd(hvi_pkg::HVI_CMD_ADDR, r);
		check({31'h0, r[0]}, 32'h1);
		if (stress) begin
			ce = 1'b0;
			repeat (40) @(posedge mclk);
			#1 ce = 1'b1;
		end
		k = 0;
		do begin
			bus_rd(hvi_pkg::HVI_CMD_ADDR, r);
			k++;
		end while (r[0] !== 1'b0 && k < 1000);
		check({31'h0, ($time - t0) <= 10000}, 32'h1);
		tag = c[3:0];
		if (c[3]) begin
			txok = ack;
			if (ack) mreg[c[0]] = db;
			if (ack && !c[0]) cfg0 = db;
		end else begin
			rxok = ack;
			if (ack) db = mreg[c[1:0]];
		end
		chk_regs();
		$display("test command %h done", c);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	initial begin
		{rst_b, mmr_wr, mmr_rd, txok, rxok, tag, db, cfg0} = '0;
		{mmr_addr, mmr_wdata} = '0;
		ce = 1'b1;
		ack_en = 1'b1;
		seed = 32'h857837f2;
		mreg = '{8'h00, 8'h00, STA_V, MON_V};
		bad = '{8'h04, 8'h07, 8'h0a, 8'h10, 8'hff};
		repeat (6) @(posedge mclk);
		#1 rst_b = 1'b1;
		chk_regs();
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			db = seed[7:0];
			// bits above the register are random and must not stick; the tag is written as zero
			bus_wr(hvi_pkg::HVI_DATA_ADDR, {seed[31:12], 4'h0, seed[7:0]});
			chk_regs();
			run_cmd({7'h04, i[0]}, i != 5, i == 3);
			run_cmd({6'h00, i[1:0]}, i != 6, 1'b0);
		end
		foreach (bad[j]) begin
			bus_wr(hvi_pkg::HVI_CMD_ADDR, {24'h0, bad[j]});
			chk_regs();
		end
		bus_wr(32'hffff0808, 32'h000000ff);
		bus_rd(32'hffff0808, r);
		check(r, 32'h0);
		chk_regs();
		$display("test refused and unmapped done");
		end_sim();
	end
endmodule
